// file: bench/tb_pll_divider_output_router.sv
// self-checking bench for the pll divider and output router
module tb_pll_divider_output_router
    import pll_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, vco_tick, scl, sda_drv, sda_out, sda_oe_n, ok;
    logic        ref_tick = 1'b0;
    logic [5:0]  outs;
    logic [11:0] product_total;
    logic [7:0]  total_reference_divider, load_capacitor_code, rd;
    logic [2:0]  pump_code;
    int          failures, checked;
    int          tick_cnt = 0;
    logic [7:0]  offs [11] = '{8'h09, 8'h0c, 8'h13, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h46,
                               8'h47, 8'h20};
    logic [7:0]  rsts [11] = '{8'h00, 8'h08, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f,
                               8'h08, 8'h00};
    wire         sda_line = sda_drv & (sda_oe_n | sda_out);

    pll_divider_output_router u_pll_divider_output_router (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .ref_tick(ref_tick), .vco_tick(vco_tick), .low_swing_output_1(outs[0]),
        .low_swing_output_2(outs[1]), .low_swing_output_3(outs[2]),
        .low_swing_output_4(outs[3]), .core_swing_output_5(outs[4]),
        .core_swing_output_6(outs[5]), .product_total(product_total),
        .total_reference_divider(total_reference_divider), .pump_code(pump_code),
        .load_capacitor_code(load_capacitor_code));
    twowire_host #(.DEV(7'h2a)) u_twowire_host (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // reference pulse every fourth clock, vco pulse every clock
    always @(posedge clk)
    begin
        tick_cnt <= (tick_cnt + 1) % 4;
        ref_tick <= (tick_cnt == 3);
    end
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rate(input int got, input int exp);
        checked++;
        if ((exp == 0) ? (got != 0) : (got > exp + 1 || got + 1 < exp))
        begin
            failures++;
            $display("wrong value at %0t: %0d edges expected %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_twowire_host.write_reg(a, d, ok);
        check_val({11'h0, ok}, 12'h001);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_twowire_host.read_reg(a, rd);
        check_val({4'h0, rd}, {4'h0, e});
    endtask
    // rising edges of each output over 960 clocks
    task automatic measure(input int e0, e1, e2, e3, e4, e5);
        int         n [6];
        int         e [6];
        logic [5:0] p;
        e = '{e0, e1, e2, e3, e4, e5};
        n = '{default: 0};
        p = outs;
        repeat (960)
        begin
            @(negedge clk);
            for (int i = 0; i < 6; i++)
                n[i] += int'(outs[i] & !p[i]);
            p = outs;
        end
        for (int i = 0; i < 6; i++)
            check_rate(n[i], e[i]);
    endtask
    task automatic complete_run();
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        vco_tick = 1'b1;
        failures = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_val(product_total, 12'h008);
        check_val({4'h0, total_reference_divider}, 12'h002);
        foreach (offs[i])
            rd_chk(offs[i], rsts[i]);
        wr(OFF_OUT_ENABLE, 8'hff);
        rd_chk(OFF_OUT_ENABLE, 8'h3f);
        wr(OFF_PUMP_PBHI, 8'h09);
        wr(OFF_PB_LOW, 8'h2c);
        wr(OFF_ODD_REF, 8'h00);
        rd_chk(OFF_PUMP_PBHI, 8'hc9);
        check_val(product_total, 12'h260);
        check_val({9'h0, pump_code}, 12'h002);
        wr(OFF_PUMP_PBHI, 8'h13);
        wr(OFF_PB_LOW, 8'hff);
        wr(OFF_ODD_REF, 8'hff);
        check_val(product_total, 12'h807);
        check_val({4'h0, total_reference_divider}, 12'h081);
        check_val({9'h0, pump_code}, 12'h004);
        wr(OFF_LOAD_CAP, 8'ha5);
        check_val({4'h0, load_capacitor_code}, 12'h0a5);
        wr(OFF_BANK1, 8'h88);
        wr(OFF_BANK2, 8'h08);
        wr(OFF_XBAR_A, 8'h28);
        wr(OFF_XBAR_B, 8'h4b);
        wr(OFF_XBAR_C, 8'hbf);
        rd_chk(OFF_XBAR_C, 8'hbf);
        measure(120, 480, 120, 30, 120, 60);
        wr(OFF_BANK1, 8'h86);
        wr(OFF_XBAR_A, 8'h7c);
        wr(OFF_XBAR_B, 8'hcb);
        wr(OFF_OUT_ENABLE, 8'h1f);
        measure(320, 0, 160, 30, 120, 0);
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule

// file: bench/twowire_host.sv
// two-wire host model that writes and reads device registers
module twowire_host
    import pll_cfg_pkg::*;
#(
    parameter logic [6:0] DEV = 7'h2a  // arbitrary bus address
)(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves only while scl is low, phases of five clocks each
    task automatic bit_io(input logic b, output logic got);
        sda_drv <= b;
        wait_clk(5);
        scl <= 1'b1;
        wait_clk(5);
        got = sda_line;
        scl <= 1'b0;
        wait_clk(5);
    endtask
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
        bit_io(1'b1, ack);
    endtask
    task automatic start_c();
        sda_drv <= 1'b0;
        wait_clk(5);
        scl <= 1'b0;
        wait_clk(5);
    endtask
    // extra idle after stop keeps the gap before the next start
    task automatic stop_c();
        sda_drv <= 1'b0;
        wait_clk(5);
        scl <= 1'b1;
        wait_clk(5);
        sda_drv <= 1'b1;
        wait_clk(15);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       k0, k1, k2;
        start_c();
        byte_io({DEV, 1'b0}, r, k0);
        byte_io(a, r, k1);
        byte_io(d, r, k2);
        stop_c();
        ok = !(k0 | k1 | k2);
    endtask
    // pointer set by a write with no data, then a one-byte read ended by nack
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        logic       k;
        start_c();
        byte_io({DEV, 1'b0}, r, k);
        byte_io(a, r, k);
        stop_c();
        start_c();
        byte_io({DEV, 1'b1}, r, k);
        byte_io(8'hff, d, k);
        stop_c();
    endtask
endmodule

// file: logic/pll_cfg_pkg.sv
// constants for the pll divider and output router configuration block
package pll_cfg_pkg;
    // register offsets on the two-wire bus
    localparam logic [7:0] OFF_OUT_ENABLE  = 8'h09;
    localparam logic [7:0] OFF_BANK1       = 8'h0c;
    localparam logic [7:0] OFF_LOAD_CAP    = 8'h13;
    localparam logic [7:0] OFF_PUMP_PBHI   = 8'h40;
    localparam logic [7:0] OFF_PB_LOW      = 8'h41;
    localparam logic [7:0] OFF_ODD_REF     = 8'h42;
    localparam logic [7:0] OFF_XBAR_A      = 8'h44;
    localparam logic [7:0] OFF_XBAR_B      = 8'h45;
    localparam logic [7:0] OFF_XBAR_C      = 8'h46;
    localparam logic [7:0] OFF_BANK2       = 8'h47;
    // reset values
    localparam logic [7:0] RST_OUT_ENABLE  = 8'h00;
    localparam logic [7:0] RST_BANK        = 8'h08;
    localparam logic [7:0] RST_LOAD_CAP    = 8'h00;
    localparam logic [4:0] RST_PUMP_PBHI   = 5'h00;
    localparam logic [7:0] RST_PB_LOW      = 8'h00;
    localparam logic [7:0] RST_ODD_REF     = 8'h00;
    localparam logic [7:0] RST_XBAR        = 8'h00;
    localparam logic [1:0] RST_XBAR_C      = 2'h0;
    // fixed fields
    localparam logic [2:0] PUMP_REG_FIXED  = 3'h6;
    localparam logic [5:0] XBAR_C_FIXED    = 6'h3f;
    localparam logic [1:0] OUT_EN_FIXED    = 2'h0;
    // field positions
    localparam int         ODD_BIT_POS     = 7;
    localparam int         SRC_SEL_POS     = 7;
    localparam int         PUMP_LSB        = 2;
    // product and reference divider offsets
    localparam logic [10:0] PRODUCT_BASE_ADD = 11'h004;
    localparam logic [7:0]  REF_DIV_ADD      = 8'h02;
    // 2055 needs twelve bits
    localparam logic [11:0] PRODUCT_MIN      = 12'h008;
    localparam logic [11:0] PRODUCT_MAX      = 12'h807;
    // crosspoint codes
    localparam logic [2:0] XP_REFERENCE    = 3'h0;
    localparam logic [2:0] XP_B1_PROG      = 3'h1;
    localparam logic [2:0] XP_B1_HALF      = 3'h2;
    localparam logic [2:0] XP_B1_THIRD     = 3'h3;
    localparam logic [2:0] XP_B2_PROG      = 3'h4;
    localparam logic [2:0] XP_B2_HALF      = 3'h5;
    localparam logic [2:0] XP_B2_QUARTER   = 3'h6;
    localparam logic [2:0] XP_RESERVED     = 3'h7;
    // serial byte framing: eight data bits then the acknowledge bit
    localparam logic [3:0] BITS_DATA       = 4'h8;
    localparam logic [3:0] BITS_FRAME      = 4'h9;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_REG   = 5'b00100,
        ST_WDATA = 5'b01000,
        ST_RDATA = 5'b10000
    } serial_state_t;
endpackage

// file: logic/pll_divider_output_router.sv
// two-wire register slave, post-divider banks and output crosspoint of a one-pll generator
// Summary of operation
// (R1) vco rate is reference over total reference divider times total product count
// (R2) total product count equals two times (base plus four) plus odd bit
// (R3) product base is 40H bits 1..0 above all of 41H
// (R4) odd bit is 42H bit 7, reference divider is 42H bits 6..0
// (R5) total product count spans 8 to 2055
// (R6) top three bits of 40H are fixed and ignore writes
// (R7) charge pump code lives in 40H bits 4..2
// (R8) host picks pump code from product count and never uses 101..111
// (R9) each bank mux picks vco or reference as its input clock
// (R10) 0CH bit 7 selects bank one source, bits 6..0 its divider
// (R11) 47H bit 7 selects bank two source, bits 6..0 its divider
// (R12) bank dividers run 4 to 127, host never programs below 4
// (R13) each output has a three-bit crosspoint code packed in 44H..46H
// (R14) codes: ref, b1 prog, b1/2, b1/3, b2 prog, b2/2, b2/4, reserved
// (R15) host writes 46H bits 5..0 with their fixed ones
// (R16) 09H bits 5..0 enable the six outputs when one
// (R17) bank one /2 aligns when divider multiple of four, /3 when six
// (R18) bank two /2 aligns when divider multiple of four, /4 when eight
// (R19) host uses fixed taps only with matching divider, unused divider set 8
// (R20) host never writes test, reserved or blank registers
// (R21) total reference divider is the seven-bit field plus two
// (R22) write is device address, register address, data bytes, each acknowledged
module pll_divider_output_router
    import pll_cfg_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a  // arbitrary bus address
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        ref_tick,
    input  wire logic        vco_tick,
    output logic             low_swing_output_1,
    output logic             low_swing_output_2,
    output logic             low_swing_output_3,
    output logic             low_swing_output_4,
    output logic             core_swing_output_5,
    output logic             core_swing_output_6,
    output logic [11:0]      product_total,
    output logic [7:0]       total_reference_divider,
    output logic [2:0]       pump_code,
    output logic [7:0]       load_capacitor_code
);
    // register storage
    logic [7:0]    out_en_reg;
    logic [7:0]    bank_reg [2];
    logic [7:0]    load_cap_reg;
    logic [4:0]    pump_pbhi_reg;
    logic [7:0]    pb_low_reg;
    logic [7:0]    odd_ref_reg;
    logic [7:0]    xbar_a_reg;
    logic [7:0]    xbar_b_reg;
    logic [1:0]    xbar_c_reg;
    // serial front end
    logic [2:0]    scl_sync_reg;
    logic [2:0]    sda_sync_reg;
    logic          scl_f_reg;
    logic          sda_f_reg;
    serial_state_t state_reg;
    logic [3:0]    bit_cnt_reg;
    logic [7:0]    shift_reg;
    logic [7:0]    ptr_reg;
    logic          sda_oe_n_reg;
    logic          sda_out_reg;
    // clock path
    logic          ref_level_reg;
    logic [5:0]    out_reg;
    logic [11:0]   product_total_reg;
    logic [7:0]    ref_total_reg;

    // a pin level is accepted only when the second and third stages agree
    wire scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    wire sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    wire scl_rise   = scl_f_next & ~scl_f_reg;
    wire scl_fall   = ~scl_f_next & scl_f_reg;
    wire start_seen = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
    wire stop_seen  = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
    wire byte_end   = scl_fall & (bit_cnt_reg == BITS_DATA);
    wire frame_end  = scl_fall & (bit_cnt_reg == BITS_FRAME);
    wire addr_hit   = (shift_reg[7:1] == DEVICE_ADDR);
    wire wr_fire    = byte_end & (state_reg == ST_WDATA);                  // R22

    wire wr_out_en  = wr_fire & (ptr_reg == OFF_OUT_ENABLE);
    wire wr_bank1   = wr_fire & (ptr_reg == OFF_BANK1);
    wire wr_bank2   = wr_fire & (ptr_reg == OFF_BANK2);
    wire wr_load    = wr_fire & (ptr_reg == OFF_LOAD_CAP);
    wire wr_pump    = wr_fire & (ptr_reg == OFF_PUMP_PBHI);
    wire wr_pb_low  = wr_fire & (ptr_reg == OFF_PB_LOW);
    wire wr_odd_ref = wr_fire & (ptr_reg == OFF_ODD_REF);
    wire wr_xbar_a  = wr_fire & (ptr_reg == OFF_XBAR_A);
    wire wr_xbar_b  = wr_fire & (ptr_reg == OFF_XBAR_B);
    wire wr_xbar_c  = wr_fire & (ptr_reg == OFF_XBAR_C);

    // readback view; fixed fields always read their preset values
    function automatic logic [7:0] read_view(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        if (addr == OFF_OUT_ENABLE)      v = {OUT_EN_FIXED, out_en_reg[5:0]};
        else if (addr == OFF_BANK1)      v = bank_reg[0];
        else if (addr == OFF_LOAD_CAP)   v = load_cap_reg;
        else if (addr == OFF_PUMP_PBHI)  v = {PUMP_REG_FIXED, pump_pbhi_reg};   // R6
        else if (addr == OFF_PB_LOW)     v = pb_low_reg;
        else if (addr == OFF_ODD_REF)    v = odd_ref_reg;
        else if (addr == OFF_XBAR_A)     v = xbar_a_reg;
        else if (addr == OFF_XBAR_B)     v = xbar_b_reg;
        else if (addr == OFF_XBAR_C)     v = {xbar_c_reg, XBAR_C_FIXED};
        else if (addr == OFF_BANK2)      v = bank_reg[1];
        return v;
    endfunction

    wire [7:0] read_next = read_view(ptr_reg);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_f_reg    <= scl_f_next;
            sda_f_reg    <= sda_f_next;
        end
    end

    // byte engine: bits counted on scl rise, acknowledge driven after the eighth fall
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            ptr_reg      <= 8'h00;
            sda_oe_n_reg <= 1'b1;
            sda_out_reg  <= 1'b0;
        end
        else if (start_seen)
        begin
            state_reg    <= ST_ADDR;
            bit_cnt_reg  <= 4'h0;
            sda_oe_n_reg <= 1'b1;
        end
        else if (stop_seen)
        begin
            state_reg    <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
        end
        else if (state_reg != ST_IDLE)
        begin
            if (scl_rise)
            begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (state_reg != ST_RDATA)
                begin
                    // the ninth bit is the acknowledge; keep the received byte intact
                    if (bit_cnt_reg != BITS_DATA)
                        shift_reg <= {shift_reg[6:0], sda_f_next};
                end
                else if (bit_cnt_reg == BITS_DATA && sda_f_next)
                    state_reg <= ST_IDLE;          // master refused further bytes
            end
            else if (byte_end)
            begin
                case (state_reg)
                    ST_ADDR:
                    begin
                        if (addr_hit)
                            sda_oe_n_reg <= 1'b0;                          // R22
                        else
                            state_reg <= ST_IDLE;
                    end
                    ST_REG:
                    begin
                        ptr_reg      <= shift_reg;
                        sda_oe_n_reg <= 1'b0;                              // R22
                    end
                    ST_WDATA:
                    begin
                        ptr_reg      <= ptr_reg + 8'h01;
                        sda_oe_n_reg <= 1'b0;                              // R22
                    end
                    default:
                        sda_oe_n_reg <= 1'b1;
                endcase
            end
            else if (frame_end)
            begin
                bit_cnt_reg <= 4'h0;
                if (state_reg == ST_RDATA || (state_reg == ST_ADDR && shift_reg[0]))
                begin
                    // read: present msb of the addressed register, then advance
                    state_reg    <= ST_RDATA;
                    shift_reg    <= read_next;
                    sda_oe_n_reg <= read_next[7];
                    ptr_reg      <= ptr_reg + 8'h01;
                end
                else
                begin
                    state_reg    <= (state_reg == ST_ADDR) ? ST_REG : ST_WDATA;
                    sda_oe_n_reg <= 1'b1;
                end
            end
            else if (scl_fall && state_reg == ST_RDATA && bit_cnt_reg != 4'h0)
            begin
                shift_reg    <= {shift_reg[6:0], 1'b1};
                sda_oe_n_reg <= shift_reg[6];
            end
        end
    end

    // register file; bytes for unlisted offsets are dropped
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            out_en_reg    <= RST_OUT_ENABLE;
            bank_reg[0]   <= RST_BANK;
            bank_reg[1]   <= RST_BANK;
            load_cap_reg  <= RST_LOAD_CAP;
            pump_pbhi_reg <= RST_PUMP_PBHI;
            pb_low_reg    <= RST_PB_LOW;
            odd_ref_reg   <= RST_ODD_REF;
            xbar_a_reg    <= RST_XBAR;
            xbar_b_reg    <= RST_XBAR;
            xbar_c_reg    <= RST_XBAR_C;
        end
        else
        begin
            if (wr_out_en)  out_en_reg    <= {OUT_EN_FIXED, shift_reg[5:0]};  // R16
            if (wr_bank1)   bank_reg[0]   <= shift_reg;                       // R10
            if (wr_bank2)   bank_reg[1]   <= shift_reg;                       // R11
            if (wr_load)    load_cap_reg  <= shift_reg;
            if (wr_pump)    pump_pbhi_reg <= shift_reg[4:0];                  // R6 R7
            if (wr_pb_low)  pb_low_reg    <= shift_reg;                       // R3
            if (wr_odd_ref) odd_ref_reg   <= shift_reg;                       // R4
            if (wr_xbar_a)  xbar_a_reg    <= shift_reg;                       // R13
            if (wr_xbar_b)  xbar_b_reg    <= shift_reg;                       // R13
            if (wr_xbar_c)  xbar_c_reg    <= shift_reg[7:6];                  // R13
        end
    end

    // pll counter totals handed to the analog loop
    wire [9:0]  product_base = {pump_pbhi_reg[1:0], pb_low_reg};              // R3
    wire [11:0] product_next = {({1'b0, product_base} + PRODUCT_BASE_ADD),
                                odd_ref_reg[ODD_BIT_POS]};                    // R2 R1
    wire [7:0]  ref_total_next = {1'b0, odd_ref_reg[6:0]} + REF_DIV_ADD;      // R21 R1

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            product_total_reg <= PRODUCT_MIN;
            ref_total_reg     <= REF_DIV_ADD;
        end
        else
        begin
            product_total_reg <= product_next;
            ref_total_reg     <= ref_total_next;
        end
    end

    // the reference source is shown as a level that toggles on each reference tick
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ref_level_reg <= 1'b0;
        else if (ref_tick)
            ref_level_reg <= ~ref_level_reg;
    end

    // divider banks: taps restart with the programmable counter so rising edges coincide
    logic [2:0] bank_src [2];
    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_bank
            localparam logic [2:0] TAP_MOD = (b == 0) ? 3'h3 : 3'h4;
            logic [6:0] cnt_reg;
            logic       half_ph_reg;
            logic [1:0] tap_ph_reg;
            logic       prog_reg;
            logic       half_reg;
            logic       tap_reg;
            wire        tick     = bank_reg[b][SRC_SEL_POS] ? vco_tick : ref_tick;   // R9
            wire [6:0]  div_n    = bank_reg[b][6:0];
            wire        wrap     = (cnt_reg >= div_n - 7'h01);
            wire [6:0]  cnt_next = wrap ? 7'h00 : cnt_reg + 7'h01;                    // R12
            wire        half_ph_next = wrap ? 1'b0 : ~half_ph_reg;                    // R17 R18
            wire [1:0]  tap_ph_next  = (wrap || tap_ph_reg == TAP_MOD[1:0] - 2'h1)
                                       ? 2'h0 : tap_ph_reg + 2'h1;                    // R17 R18
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    // start at the wrap point so the first tick restarts all taps together
                    cnt_reg     <= 7'h7f;
                    half_ph_reg <= 1'b0;
                    tap_ph_reg  <= 2'h0;
                    prog_reg    <= 1'b0;
                    half_reg    <= 1'b0;
                    tap_reg     <= 1'b0;
                end
                else if (tick)
                begin
                    cnt_reg     <= cnt_next;
                    half_ph_reg <= half_ph_next;
                    tap_ph_reg  <= tap_ph_next;
                    prog_reg    <= (cnt_next < {1'b0, div_n[6:1]});
                    half_reg    <= ~half_ph_next;
                    tap_reg     <= (tap_ph_next < TAP_MOD[2:1]);
                end
            end
            assign bank_src[b] = {tap_reg, half_reg, prog_reg};
        end
    endgenerate

    // crosspoint: six three-bit codes packed msb first across 44H, 45H, 46H[7:6]
    wire [17:0] xbar_codes = {xbar_a_reg, xbar_b_reg, xbar_c_reg};
    wire [6:0]  sources    = {bank_src[1], bank_src[0], ref_level_reg};

    function automatic logic pick(input logic [2:0] code, input logic [6:0] src);
        logic s;
        s = 1'b0;
        if (code != XP_RESERVED)
            s = src[code];                                                    // R14
        return s;
    endfunction

    wire [5:0] out_next;
    genvar o;
    generate
        for (o = 0; o < 6; o++)
        begin : g_out
            wire [2:0] code = xbar_codes[17 - 3*o -: 3];                      // R13
            assign out_next[o] = out_en_reg[o] & pick(code, sources);         // R16 R14
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            out_reg <= 6'h00;
        else
            out_reg <= out_next;
    end

    assign sda_out                 = sda_out_reg;
    assign sda_oe_n                = sda_oe_n_reg;
    assign low_swing_output_1      = out_reg[0];
    assign low_swing_output_2      = out_reg[1];
    assign low_swing_output_3      = out_reg[2];
    assign low_swing_output_4      = out_reg[3];
    assign core_swing_output_5     = out_reg[4];
    assign core_swing_output_6     = out_reg[5];
    assign product_total           = product_total_reg;
    assign total_reference_divider = ref_total_reg;
    assign pump_code               = pump_pbhi_reg[4:PUMP_LSB];
    assign load_capacitor_code     = load_cap_reg;

    property p_product;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> product_total == ({2'h0, $past(product_base)} + 12'h004) * 12'h002
                 + {11'h000, $past(odd_ref_reg[7])};
    endproperty
    a_product: assert property (p_product) else $error("product total wrong"); // R2
    property p_range;
        @(posedge clk) disable iff (!rst_n)
        product_total >= PRODUCT_MIN && product_total <= PRODUCT_MAX;
    endproperty
    a_range: assert property (p_range) else $error("product total out of range"); // R5
    property p_ref_total;
        @(posedge clk) disable iff (!rst_n)
        wr_odd_ref |=> ##1 total_reference_divider == {1'b0, $past(shift_reg[6:0], 2)} + 8'd2;
    endproperty
    a_ref_total: assert property (p_ref_total) else $error("reference total wrong"); // R21
    property p_fixed_top;
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_RDATA && $past(frame_end) && $past(ptr_reg) == OFF_PUMP_PBHI
            |-> shift_reg[7:5] == 3'h6;
    endproperty
    a_fixed_top: assert property (p_fixed_top) else $error("40H top bits changed"); // R6
    property p_bank1_write;
        @(posedge clk) disable iff (!rst_n)
        wr_bank1 |=> bank_reg[0] == $past(shift_reg) && bank_reg[0][7] == $past(shift_reg[7]);
    endproperty
    a_bank1_write: assert property (p_bank1_write) else $error("bank one not loaded"); // R10
    property p_disabled;
        @(posedge clk) disable iff (!rst_n)
        !out_en_reg[0] |=> !low_swing_output_1;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled output toggles"); // R16
    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        xbar_codes[14:12] == 3'h7 |=> !low_swing_output_2;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code drives"); // R14
    property p_align1;
        @(posedge clk) disable iff (!rst_n)
        $rose(g_bank[0].prog_reg) && bank_reg[0][1:0] == 2'b00 |-> $rose(g_bank[0].half_reg);
    endproperty
    a_align1: assert property (p_align1) else $error("bank one half misaligned"); // R17
    property p_align2;
        @(posedge clk) disable iff (!rst_n)
        $rose(g_bank[1].prog_reg) && bank_reg[1][2:0] == 3'b000 |-> $rose(g_bank[1].tap_reg);
    endproperty
    a_align2: assert property (p_align2) else $error("bank two quarter misaligned"); // R18
endmodule
